// file: verilog/sdc_map.svh
// constants for the command decoder
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
`define SDC_AUTOCLOSE_BIT 10
`define SDC_CHOP_BIT 12
`define SDC_MR_BURST_SEL 4'h0
`define SDC_BL_FIXED_EIGHT 2'h0
`define SDC_BL_PER_CMD 2'h1
`define SDC_BL_FIXED_FOUR 2'h2
`define SDC_BURST8_CLKS 3'h4
`define SDC_BURST4_CLKS 3'h2
`define SDC_WORD_W 28
`endif

// file: verilog/sdc_pkg.sv
// types for the command decoder
package sdc_pkg;
  typedef enum logic [3:0] {
    cmd_deselect = 4'h0,
    cmd_mode_reg_write = 4'h1,
    cmd_refresh = 4'h2,
    cmd_sleep_renewal_entry = 4'h3,
    cmd_sleep_renewal_exit = 4'h4,
    cmd_precharge = 4'h5,
    cmd_close_all_rows = 4'h6,
    cmd_reserved_code = 4'h7,
    cmd_open_row = 4'h8,
    cmd_write = 4'h9,
    cmd_read = 4'hA,
    cmd_idle_no_op = 4'hB,
    cmd_powerdown_entry = 4'hC,
    cmd_powerdown_exit = 4'hD,
    cmd_impedance_cal_long = 4'hE,
    cmd_impedance_cal_short = 4'hF
  } sdc_cmd_t;
  typedef enum logic [1:0] {
    md_idle = 2'h0,
    md_powerdown = 2'h1,
    md_self_refresh = 2'h2
  } sdc_mode_t;
endpackage : sdc_pkg

// file: verilog/sdc_decoder.sv
// command pin decoder with crossing of decoded commands to the system clock
`include "sdc_map.svh"
// Function
// - sample select, row select, three shared pins and clock gate each rising edge
// - row select high: shared pins act as row, column and write strobes
// - row select low with chip select low: shared pins are row bits 16..14, open row
// - upper group, bank, row, column bits depend on density and width
// - group and bank inputs together pick one bank for bank commands
// - mode write: group and bank pick register, address pins are opcode
// - highest row bit is reserved during a mode write
// - read/write: autoclose pin selects auto-close, chop pin selects four or eight
// - a started burst runs to its end, never cut short
// - fixed or per-command burst length is set by a mode write
// - termination control does not affect decoding, off in self refresh
// - device detects self refresh exit synchronously here
// - no internal refresh activity while powered down
// - chip select high with clock gate steady high: no new command, running work continues
module sdc_decoder (
  input wire logic ck_i, // link clock from controller
  input wire logic reset_n_i, // asynchronous reset, active low
  input wire logic cke_i, // clock-gate enable
  input wire logic cs_n_i, // chip select, active low
  input wire logic open_row_sel_low_i, // open-row select, active low
  input wire logic row_strobe_shared_pin_i, // row strobe or row bit 16
  input wire logic column_strobe_shared_pin_i, // column strobe or row bit 15
  input wire logic write_enable_shared_pin_i, // write enable or row bit 14
  input wire logic [1:0] group_select_i, // bank group
  input wire logic [1:0] bank_i, // bank address
  input wire logic [13:0] addr_i, // address bits 13..0
  input wire logic highest_row_bit_i, // address bit 17
  input wire logic termination_ctrl_i, // termination control
  input wire logic clk_i, // system clock
  input wire logic rst_i, // system reset, active high
  input wire logic drop_clr_i, // clears dropped flag
  output sdc_pkg::sdc_cmd_t cmd_o, // decoded command
  output logic cmd_valid_o, // one-cycle pulse per command not dropped in the crossing
  output logic [1:0] group_o, // bank group of command
  output logic [1:0] bank_o, // bank of command
  output logic [17:0] addr_o, // row, column or opcode
  output logic autoclose_o, // auto-close or all banks
  output logic chop_four_o, // four-beat burst
  output sdc_pkg::sdc_mode_t mode_o, // power state
  output logic burst_active_o, // burst under way
  output logic term_enable_o, // termination usable
  output logic per_cmd_sel_o, // per-command burst length
  output logic int_refresh_o, // internal refresh active
  output logic dropped_o // a command was lost in the crossing
);
  import sdc_pkg::*;

  // ---------------- link domain ----------------
  logic cke_prev_q;
  logic [2:0] cbits;
  logic autoclose_flag_pin;
  logic chop_select_pin;
  logic both_hi;
  sdc_cmd_t cmd_d;
  sdc_cmd_t cmd_q;
  logic [1:0] grp_q;
  logic [1:0] bank_q;
  logic [17:0] addr_q;
  logic autoclose_q;
  logic chop_q;
  sdc_mode_t mode_q;
  sdc_mode_t mode_d;
  logic per_cmd_q;
  logic fixed4_q;
  logic [2:0] burst_cnt_q;
  logic term_en_q;
  logic int_refresh_q;
  logic [`SDC_WORD_W-1:0] hold_q;
  logic req_q;
  logic busy;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_s3_q;
  logic ack_seen_q;
  logic drop_tgl_q;
  logic ack_q;

  // shared pins read as strobes only when row select is high
  assign cbits = {row_strobe_shared_pin_i, column_strobe_shared_pin_i,
                  write_enable_shared_pin_i};
  assign autoclose_flag_pin = addr_i[`SDC_AUTOCLOSE_BIT];
  assign chop_select_pin = addr_i[`SDC_CHOP_BIT];
  assign both_hi = cke_prev_q & cke_i;

  // termination control is deliberately absent from this decode
  always_comb begin
    cmd_d = cmd_deselect;
    if (both_hi) begin
      if (!cs_n_i) begin
        if (!open_row_sel_low_i) begin
          cmd_d = cmd_open_row;
        end else begin
          case (cbits)
            3'h0: cmd_d = cmd_mode_reg_write;
            3'h1: cmd_d = cmd_refresh;
            3'h2: cmd_d = autoclose_flag_pin ? cmd_close_all_rows : cmd_precharge;
            3'h3: cmd_d = cmd_reserved_code;
            3'h4: cmd_d = cmd_write;
            3'h5: cmd_d = cmd_read;
            3'h6: cmd_d = autoclose_flag_pin ? cmd_impedance_cal_long
                                             : cmd_impedance_cal_short;
            3'h7: cmd_d = cmd_idle_no_op;
            default: cmd_d = cmd_deselect;
          endcase
        end
      end
    end else if (cke_prev_q && !cke_i) begin
      if (cs_n_i) begin
        cmd_d = cmd_powerdown_entry;
      end else if (open_row_sel_low_i && cbits == 3'h1) begin
        cmd_d = cmd_sleep_renewal_entry;
      end
    end else if (!cke_prev_q && cke_i) begin
      // exits are taken on the clock edge; a rising gate outside power-down and self refresh is no exit
      if (mode_q == md_self_refresh) begin
        cmd_d = cmd_sleep_renewal_exit;
      end else if (cs_n_i && mode_q == md_powerdown) begin
        cmd_d = cmd_powerdown_exit;
      end
    end
  end

  // the reset pin acts only asynchronously
  always_ff @(posedge ck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cke_prev_q <= 1'b0;
      cmd_q <= cmd_deselect;
      grp_q <= 2'h0;
      bank_q <= 2'h0;
      addr_q <= 18'h0;
      autoclose_q <= 1'b0;
      chop_q <= 1'b0;
    end else begin
      cke_prev_q <= cke_i;
      cmd_q <= cmd_d;
      grp_q <= group_select_i;
      bank_q <= bank_i;
      autoclose_q <= autoclose_flag_pin;
      chop_q <= per_cmd_q ? !chop_select_pin : fixed4_q;
      if (cmd_d == cmd_open_row) begin
        addr_q <= {highest_row_bit_i, cbits, addr_i};
      end else begin
        addr_q <= {4'h0, addr_i};
      end
    end
  end

  // burst length mode lives here, only a mode write to register 0 changes it
  always_ff @(posedge ck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      per_cmd_q <= 1'b0;
      fixed4_q <= 1'b0;
    end else if (cmd_q == cmd_mode_reg_write && {grp_q, bank_q} == `SDC_MR_BURST_SEL) begin
      per_cmd_q <= addr_q[1:0] == `SDC_BL_PER_CMD;
      fixed4_q <= addr_q[1:0] == `SDC_BL_FIXED_FOUR;
    end
  end

  // a new read or write while counting does not restart or cut the burst
  always_ff @(posedge ck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      burst_cnt_q <= 3'h0;
    end else if (burst_cnt_q != 3'h0) begin
      burst_cnt_q <= burst_cnt_q - 3'h1;
    end else if (cmd_q == cmd_read || cmd_q == cmd_write) begin
      burst_cnt_q <= chop_q ? `SDC_BURST4_CLKS : `SDC_BURST8_CLKS;
    end
  end

  always_comb begin
    case (cmd_q)
      cmd_powerdown_entry: mode_d = md_powerdown;
      cmd_sleep_renewal_entry: mode_d = md_self_refresh;
      cmd_powerdown_exit: mode_d = md_idle;
      cmd_sleep_renewal_exit: mode_d = md_idle;
      default: mode_d = mode_q;
    endcase
  end

  always_ff @(posedge ck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= md_idle;
      term_en_q <= 1'b0;
      int_refresh_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      term_en_q <= termination_ctrl_i && mode_d != md_self_refresh;
      int_refresh_q <= mode_d == md_self_refresh;
    end
  end

  // one command in flight; commands arriving while busy are dropped
  // because the system clock is slower than the link
  assign busy = req_q != ack_seen_q;

  always_ff @(posedge ck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_q <= '0;
      req_q <= 1'b0;
      drop_tgl_q <= 1'b0;
    end else if (cmd_q != cmd_deselect) begin
      if (!busy) begin
        hold_q <= {cmd_q, grp_q, bank_q, addr_q, autoclose_q, chop_q};
        req_q <= !req_q;
      end else begin
        drop_tgl_q <= !drop_tgl_q;
      end
    end
  end

  always_ff @(posedge ck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      ack_seen_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      if (ack_s2_q == ack_s3_q) begin
        ack_seen_q <= ack_s3_q;
      end
    end
  end

  // ---------------- system domain ----------------
  logic [2:0] req_s_q;
  logic [2:0] drop_s_q;
  logic drop_seen_q;
  logic [4:0] lvl_src;
  logic [4:0] lvl_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_s_q <= 3'h0;
      drop_s_q <= 3'h0;
    end else begin
      req_s_q <= {req_s_q[1:0], req_q};
      drop_s_q <= {drop_s_q[1:0], drop_tgl_q};
    end
  end

  // held word is stable while the request toggle is unanswered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_o <= cmd_deselect;
      group_o <= 2'h0;
      bank_o <= 2'h0;
      addr_o <= 18'h0;
      autoclose_o <= 1'b0;
      chop_four_o <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      if (req_s_q[1] == req_s_q[2] && req_s_q[2] != ack_q) begin
        ack_q <= req_s_q[2];
        cmd_valid_o <= 1'b1;
        cmd_o <= sdc_cmd_t'(hold_q[27:24]);
        {group_o, bank_o, addr_o, autoclose_o, chop_four_o} <= hold_q[23:0];
      end
    end
  end

  // a new drop in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_seen_q <= 1'b0;
      dropped_o <= 1'b0;
    end else if (drop_s_q[1] == drop_s_q[2] && drop_s_q[2] != drop_seen_q) begin
      drop_seen_q <= drop_s_q[2];
      dropped_o <= 1'b1;
    end else if (drop_clr_i) begin
      dropped_o <= 1'b0;
    end
  end

  assign lvl_src = {mode_q, burst_cnt_q != 3'h0, term_en_q, per_cmd_q};

  generate
    for (genvar i = 0; i < 5; i++) begin : g_lvl
      logic [2:0] s_q;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          s_q <= 3'h0;
          lvl_q[i] <= 1'b0;
        end else begin
          s_q <= {s_q[1:0], lvl_src[i]};
          if (s_q[1] == s_q[2]) begin
            lvl_q[i] <= s_q[2];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= md_idle;
      burst_active_o <= 1'b0;
      term_enable_o <= 1'b0;
      per_cmd_sel_o <= 1'b0;
      int_refresh_o <= 1'b0;
    end else begin
      mode_o <= sdc_mode_t'(lvl_q[4:3]);
      burst_active_o <= lvl_q[2];
      term_enable_o <= lvl_q[1];
      per_cmd_sel_o <= lvl_q[0];
      int_refresh_o <= lvl_q[4:3] == md_self_refresh;
    end
  end

  // ---------------- checks ----------------
  AST_DESELECT: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    both_hi && cs_n_i |=> cmd_q == cmd_deselect)
    else $error("deselect decoded as a command");
  AST_OPEN_ROW: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    both_hi && !cs_n_i && !open_row_sel_low_i
    |=> cmd_q == cmd_open_row && addr_q[16:14] == $past(cbits))
    else $error("open row or row bits wrong");
  AST_MODE_WRITE: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    both_hi && !cs_n_i && open_row_sel_low_i && cbits == 3'h0
    |=> cmd_q == cmd_mode_reg_write && grp_q == $past(group_select_i) && addr_q[17] == 1'b0)
    else $error("mode write decode wrong");
  AST_READ_AUTOCLOSE: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    both_hi && !cs_n_i && open_row_sel_low_i && cbits == 3'h5
    |=> cmd_q == cmd_read && autoclose_q == $past(autoclose_flag_pin))
    else $error("read decode wrong");
  AST_CHOP: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    $past(per_cmd_q) && !$past(chop_select_pin) |-> chop_q)
    else $error("per-command chop not honoured");
  AST_BURST_RUNS: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    burst_cnt_q != 3'h0 |=> burst_cnt_q == $past(burst_cnt_q) - 3'h1)
    else $error("burst interrupted");
  AST_TERM_OFF_SR: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    mode_q == md_self_refresh |-> !term_en_q)
    else $error("termination on in self refresh");
  AST_NO_REFRESH_PD: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    mode_q == md_powerdown |-> !int_refresh_q)
    else $error("refresh in power-down");
  AST_SR_ENTRY: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    cke_prev_q && !cke_i && !cs_n_i && open_row_sel_low_i && cbits == 3'h1
    |=> cmd_q == cmd_sleep_renewal_entry ##1 mode_q == md_self_refresh)
    else $error("self refresh entry missed");
  AST_PRECHARGE: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    both_hi && !cs_n_i && open_row_sel_low_i && cbits == 3'h2
    |=> cmd_q == ($past(autoclose_flag_pin) ? cmd_close_all_rows : cmd_precharge))
    else $error("precharge decode wrong");
  AST_PD_ENTRY: assert property (@(posedge ck_i) disable iff (!reset_n_i)
    cke_prev_q && !cke_i && cs_n_i |=> cmd_q == cmd_powerdown_entry ##1 mode_q == md_powerdown)
    else $error("power-down entry missed");
endmodule : sdc_decoder

// file: tb/sdc_ctrl_model.sv
// controller model that drives the command pins of the decoder from the link clock
module sdc_ctrl_model (
  input wire logic ck_i, // link clock
  input wire logic req_i, // toggles once for each pattern to send
  input wire logic [24:0] pat_i, // {cke, cs_n, open_row_sel_low, ras, cas, we, bg, ba, a17, a13..a0}
  output logic [24:0] pins_o // same layout, as seen on the pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic seen_q;

  initial begin
    seen_q = 1'b0;
    pins_o = 25'h1800000;
  end

  // pins change on the falling edge so they are settled at the sampling edge
  always @(negedge ck_i) begin
    if (req_i != seen_q) begin
      seen_q <= req_i;
      pins_o <= pat_i;
    end else begin
      // deselect keeps the clock gate; don't-care pins flip so no stale level is trusted
      pins_o <= {pins_o[24], 1'b1, ~pins_o[22:0]};
    end
  end
endmodule : sdc_ctrl_model

// file: tb/sdc_decoder_test.sv
// self-checking bench for the command decoder
module sdc_decoder_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sdc_pkg::*;
  logic clk_i = 1'b0;
  logic ck = 1'b0;
  logic rst_i = 1'b1;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic drop_clr = 1'b0;
  logic term = 1'b0;
  logic [24:0] pat = 25'h1800000;
  logic [24:0] pins;
  logic [13:0] a;
  sdc_cmd_t cmd_o;
  sdc_mode_t mode_o;
  logic cmd_valid_o, autoclose_o, chop_four_o, burst_active_o;
  logic term_enable_o, per_cmd_sel_o, int_refresh_o, dropped_o;
  logic [1:0] group_o, bank_o;
  logic [17:0] addr_o;
  int err_count = 0;
  int num_checks = 0;

  always #50 clk_i = ~clk_i;
  always #7.5 ck = ~ck;

  sdc_ctrl_model sdc_ctrl_model_inst (.ck_i(ck), .req_i(req), .pat_i(pat), .pins_o(pins));

  sdc_decoder sdc_decoder_inst (
    .ck_i(ck), .reset_n_i(rst_n), .cke_i(pins[24]), .cs_n_i(pins[23]),
    .open_row_sel_low_i(pins[22]), .row_strobe_shared_pin_i(pins[21]),
    .column_strobe_shared_pin_i(pins[20]), .write_enable_shared_pin_i(pins[19]),
    .group_select_i(pins[18:17]), .bank_i(pins[16:15]), .highest_row_bit_i(pins[14]),
    .addr_i(pins[13:0]), .termination_ctrl_i(term), .clk_i(clk_i), .rst_i(rst_i),
    .drop_clr_i(drop_clr), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .group_o(group_o),
    .bank_o(bank_o), .addr_o(addr_o), .autoclose_o(autoclose_o), .chop_four_o(chop_four_o),
    .mode_o(mode_o), .burst_active_o(burst_active_o), .term_enable_o(term_enable_o),
    .per_cmd_sel_o(per_cmd_sel_o), .int_refresh_o(int_refresh_o), .dropped_o(dropped_o)
  );

  function automatic sdc_cmd_t exp_cmd(input logic [2:0] c, input logic a10);
    case (c)
      3'h0: return cmd_mode_reg_write;
      3'h1: return cmd_refresh;
      3'h2: return a10 ? cmd_close_all_rows : cmd_precharge;
      3'h3: return cmd_reserved_code;
      3'h4: return cmd_write;
      3'h5: return cmd_read;
      3'h6: return a10 ? cmd_impedance_cal_long : cmd_impedance_cal_short;
      default: return cmd_idle_no_op;
    endcase
  endfunction : exp_cmd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // non-blocking so the model's falling-edge process always sees a whole pattern
  task automatic send(input logic cke, input logic cs, input logic act, input logic [2:0] c,
                      input logic [3:0] gb, input logic [13:0] av);
    @(negedge clk_i);
    term <= 1'($urandom);
    pat <= {cke, cs, act, c, gb, 1'($urandom), av};
    req <= ~req;
    // callers read the new pattern for their expectations
    #1;
  endtask : send

  task automatic expect_cmd(input sdc_cmd_t c, input logic [17:0] ea, input logic full);
    int n;
    for (n = 0; n < 60 && cmd_valid_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 60) begin
      err_count++;
      finish_test();
    end
    check(cmd_o, c);
    if (full) begin
      check(addr_o, ea);
      check({group_o, bank_o}, pat[18:15]);
    end
    repeat (12) @(negedge clk_i);
  endtask : expect_cmd

  initial begin
    void'($urandom(32'hD808));
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    rst_n = 1'b1;
    repeat (4) @(negedge clk_i);
    // every command code with both autoclose levels; the reserved code is never sent
    for (int i = 0; i < 16; i++) begin
      if (i[2:0] == 3'h3) continue;
      a = 14'($urandom);
      a[10] = i[3];
      send(1'b1, 1'b0, 1'b1, i[2:0], 4'($urandom), a);
      expect_cmd(exp_cmd(i[2:0], a[10]), {4'h0, pat[13:0]}, 1'b1);
    end
    $display("command codes done");
    for (int i = 0; i < 4; i++) begin
      send(1'b1, 1'b0, 1'b0, 3'($urandom), 4'($urandom), 14'($urandom));
      expect_cmd(cmd_open_row, {pat[14], pat[21:19], pat[13:0]}, 1'b1);
    end
    $display("open row done");
    for (int m = 0; m < 3; m++) begin
      send(1'b1, 1'b0, 1'b1, 3'h0, 4'h0, 14'(m));
      expect_cmd(cmd_mode_reg_write, {4'h0, 14'(m)}, 1'b1);
      check(per_cmd_sel_o, m == 1);
      for (int k = 0; k < 2; k++) begin
        a = 14'($urandom);
        a[12] = k[0];
        send(1'b1, 1'b0, 1'b1, {2'b10, k[0]}, 4'($urandom), a);
        expect_cmd(k[0] ? cmd_read : cmd_write, {4'h0, a}, 1'b1);
        check(autoclose_o, a[10]);
        check(chop_four_o, m == 2 || (m == 1 && !a[12]));
        check(burst_active_o, 1'b0);
      end
    end
    $display("burst length done");
    send(1'b1, 1'b1, 1'b0, 3'($urandom), 4'($urandom), 14'($urandom));
    repeat (30) begin
      @(negedge clk_i);
      check(cmd_valid_o, 1'b0);
    end
    $display("deselect done");
    send(1'b0, 1'b1, 1'b0, 3'($urandom), 4'($urandom), 14'($urandom));
    expect_cmd(cmd_powerdown_entry, 18'h0, 1'b0);
    check(mode_o, md_powerdown);
    check(int_refresh_o, 1'b0);
    send(1'b1, 1'b1, 1'b0, 3'($urandom), 4'($urandom), 14'($urandom));
    expect_cmd(cmd_powerdown_exit, 18'h0, 1'b0);
    check(mode_o, md_idle);
    $display("power-down done");
    send(1'b0, 1'b0, 1'b1, 3'h1, 4'($urandom), 14'($urandom));
    expect_cmd(cmd_sleep_renewal_entry, 18'h0, 1'b0);
    check(mode_o, md_self_refresh);
    check(int_refresh_o, 1'b1);
    check(term_enable_o, 1'b0);
    send(1'b1, 1'b1, 1'b0, 3'($urandom), 4'($urandom), 14'($urandom));
    expect_cmd(cmd_sleep_renewal_exit, 18'h0, 1'b0);
    check(term_enable_o, term);
    $display("self refresh done");
    // second command while the first is still crossing: it is lost and flagged
    send(1'b1, 1'b0, 1'b1, 3'h7, 4'($urandom), 14'($urandom));
    send(1'b1, 1'b0, 1'b1, 3'h6, 4'($urandom), 14'($urandom));
    expect_cmd(cmd_idle_no_op, 18'h0, 1'b0);
    check(dropped_o, 1'b1);
    drop_clr <= 1'b1;
    @(negedge clk_i);
    drop_clr <= 1'b0;
    repeat (3) @(negedge clk_i);
    check(dropped_o, 1'b0);
    $display("drop flag done");
    finish_test();
  end
endmodule : sdc_decoder_test
